//--- hdl/blink_gen.sv
`default_nettype none
module blink_gen (
  // clocking
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // divider
  input wire logic [sideband_pkg::BLINK_W-1:0] half_period,
  // phase
  output logic phase
);
  typedef struct packed {
    logic [sideband_pkg::BLINK_W-1:0] cnt;
    logic phase;
  } blink_s;
  blink_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (st_reg.cnt == '0) begin
      st_next.cnt = (half_period == '0) ? '0 : half_period - 1'b1;
      st_next.phase = ~st_reg.phase;
    end else begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign phase = st_reg.phase;

  a_blink_period: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && st_reg.cnt != '0) |=> (st_reg.phase == $past(st_reg.phase)))
    else $error("blink phase changed before count expired");
endmodule
`default_nettype wire

//--- hdl/drive_port_status_sideband.sv
`default_nettype none
module drive_port_status_sideband (
  // clocking
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // configuration
  input wire logic [1:0] lamp_option,
  input wire logic mdix_mode,
  input wire logic [sideband_pkg::BLINK_W-1:0] blink_half_period,
  // link status from phy
  input wire sideband_pkg::link_status_s link_status,
  // controller sideband
  input wire logic ctl_sense,
  input wire logic ctl_reset,
  // lamps
  output sideband_pkg::lamps_s lamps,
  // port events and status
  output logic port_reset_ind,
  output logic nexus_loss,
  output logic ctl_present,
  output logic drive_sense,
  // pair direction and autonegotiation
  output sideband_pkg::pair_dir_s pair_dir,
  output logic serial_tx_enable,
  output logic autoneg_enable
);
  typedef struct packed {
    sideband_pkg::presence_e pres;
    logic [sideband_pkg::ACT_W-1:0] act_hold;
    logic rst_seen;
    sideband_pkg::lamps_s lamps;
    logic reset_ind;
    logic loss;
    sideband_pkg::pair_dir_s dir;
  } state_s;
  state_s st_reg, st_next;
  logic blink;
  logic traffic;
  logic active;

  blink_gen u_blink (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .half_period(blink_half_period),
    .phase(blink)
  );

  function automatic logic present_state(input sideband_pkg::presence_e p);
    present_state = (p == sideband_pkg::CTL_PRESENT);
  endfunction

  assign traffic = link_status.pair_one_traffic | link_status.pair_two_traffic;
  // activity stretched so short bursts still blink visibly
  assign active = traffic || (st_reg.act_hold != '0);

  always_comb begin
    st_next = st_reg;
    st_next.reset_ind = 1'b0;
    st_next.loss = 1'b0;
    if (traffic) begin
      st_next.act_hold = sideband_pkg::ACT_W'(sideband_pkg::ACT_HOLD_CYC);
    end else if (st_reg.act_hold != '0) begin
      st_next.act_hold = st_reg.act_hold - 1'b1;
    end
    case (st_reg.pres)
      sideband_pkg::CTL_ABSENT: begin
        if (ctl_sense) begin
          st_next.pres = sideband_pkg::CTL_PRESENT;
        end
      end
      sideband_pkg::CTL_PRESENT: begin
        if (!ctl_sense) begin
          st_next.pres = sideband_pkg::CTL_LOST;
        end
      end
      sideband_pkg::CTL_LOST: begin
        st_next.pres = ctl_sense ? sideband_pkg::CTL_PRESENT : sideband_pkg::CTL_ABSENT;
      end
      default: begin
        st_next.pres = sideband_pkg::CTL_ABSENT;
      end
    endcase
    st_next.rst_seen = ctl_reset;
    if (ctl_reset && !st_reg.rst_seen) begin
      st_next.reset_ind = 1'b1;
    end
    // nexus loss on presence drop or reset
    if ((present_state(st_reg.pres) && !ctl_sense) || (ctl_reset && !st_reg.rst_seen)) begin
      st_next.loss = 1'b1;
    end
    // lamps are active high here; the open-collector pad inverts
    if (lamp_option == sideband_pkg::LAMPS_SIGNAL_ONLY) begin
      // single lamp combines presence and traffic
      st_next.lamps.activity_lamp = 1'b0;
      if (!link_status.signal_present) begin
        st_next.lamps.link_presence_lamp = 1'b0;
      end else if (!active) begin
        st_next.lamps.link_presence_lamp = 1'b1;
      end else begin
        st_next.lamps.link_presence_lamp = blink;
      end
    end else begin
      st_next.lamps.link_presence_lamp = link_status.signal_present;
      st_next.lamps.activity_lamp = active ? blink : 1'b0;
    end
    st_next.dir.pair_one_drive = mdix_mode ? sideband_pkg::PAIR_RECEIVE : sideband_pkg::PAIR_DRIVE;
    st_next.dir.pair_two_drive = mdix_mode ? sideband_pkg::PAIR_DRIVE : sideband_pkg::PAIR_RECEIVE;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign lamps = st_reg.lamps;
  assign port_reset_ind = st_reg.reset_ind;
  assign nexus_loss = st_reg.loss;
  assign ctl_present = present_state(st_reg.pres);
  assign pair_dir = st_reg.dir;
  // drive presence asserted while out of reset
  assign drive_sense = resetn;
  // we transmit on our own serial pair whenever out of reset
  assign serial_tx_enable = resetn;
  assign autoneg_enable = 1'b1;

  sequence s_rst_rise;
    clk_en && ctl_reset && !st_reg.rst_seen;
  endsequence

  a_presence_lamp: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && lamp_option == sideband_pkg::LAMPS_BOTH)
      |=> (lamps.link_presence_lamp == $past(link_status.signal_present)))
    else $error("presence lamp does not follow signal presence");
  a_activity_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && lamp_option == sideband_pkg::LAMPS_BOTH && !active)
      |=> !lamps.activity_lamp)
    else $error("activity lamp lit without traffic");
  a_single_lamp: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && lamp_option == sideband_pkg::LAMPS_SIGNAL_ONLY
      && link_status.signal_present && !active) |=> lamps.link_presence_lamp)
    else $error("single lamp not steady on while idle");
  a_reset_ind: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_rst_rise |=> (port_reset_ind && nexus_loss))
    else $error("reset input gave no reset indication");
  a_ctl_present: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && ctl_sense)[*2] |=> ctl_present)
    else $error("controller presence not tracked");
  a_pair_dir: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && mdix_mode) |=> (pair_dir.pair_two_drive && !pair_dir.pair_one_drive))
    else $error("wrong pair driven in crossed wiring");
  a_nexus_loss: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && ctl_present && !ctl_sense) |=> nexus_loss)
    else $error("no nexus loss on controller departure");
  a_lamps_reset: assert property (@(posedge ref_clk)
    !resetn |=> (lamps == '0))
    else $error("lamps lit after reset");
endmodule
`default_nettype wire

//--- hdl/sideband_pkg.sv
`default_nettype none
package sideband_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BLINK_HALF_MS = 50;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned BLINK_W = 24;
  localparam int unsigned ACT_HOLD_CYC = 16;
  localparam int unsigned ACT_W = 5;
  localparam int unsigned RST_PULSE_CYC = 1;
  // lamp option encoding
  localparam logic [1:0] LAMPS_BOTH = 2'h0;
  localparam logic [1:0] LAMPS_SIGNAL_ONLY = 2'h1;
  // pair direction flags
  localparam logic PAIR_DRIVE = 1'h1;
  localparam logic PAIR_RECEIVE = 1'h0;

  typedef enum logic [1:0] {
    CTL_ABSENT = 2'b00,
    CTL_PRESENT = 2'b01,
    CTL_LOST = 2'b11
  } presence_e;

  typedef struct packed {
    logic signal_present;
    logic pair_one_traffic;
    logic pair_two_traffic;
  } link_status_s;

  typedef struct packed {
    logic link_presence_lamp;
    logic activity_lamp;
  } lamps_s;

  typedef struct packed {
    logic pair_one_drive;
    logic pair_two_drive;
  } pair_dir_s;
endpackage
`default_nettype wire

//--- tb/ctl_model.sv
`default_nettype none
module ctl_model (
  // clock
  input wire logic ref_clk,
  // sideband
  input wire logic drive_sense,
  output logic ctl_sense,
  output logic ctl_reset,
  output logic drive_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ctl_sense = 1'h0;
    ctl_reset = 1'h0;
  end
  always @(posedge ref_clk) drive_seen <= drive_sense;
  task automatic drive(input logic s, input logic r);
    @(posedge ref_clk);
    ctl_sense <= s;
    ctl_reset <= r;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 4;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic [1:0] lamp_option = 2'h0;
  logic mdix_mode = 1'h0;
  logic clk_en = 1'h1;
  sideband_pkg::link_status_s link_status = 3'h0;
  sideband_pkg::lamps_s lamps;
  sideband_pkg::pair_dir_s pair_dir;
  logic ctl_sense, ctl_reset, drive_seen, drive_sense, serial_tx_enable;
  logic port_reset_ind, nexus_loss, ctl_present, autoneg_enable;
  int err_count = 0;
  int comparisons = 0;
  always #5 ref_clk = ~ref_clk;
  // short half period so a blink shows within a few cycles
  drive_port_status_sideband u_drive_port_status_sideband (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .lamp_option(lamp_option),
    .mdix_mode(mdix_mode), .blink_half_period(24'(HALF)), .link_status(link_status),
    .ctl_sense(ctl_sense), .ctl_reset(ctl_reset), .lamps(lamps),
    .port_reset_ind(port_reset_ind), .nexus_loss(nexus_loss), .ctl_present(ctl_present),
    .drive_sense(drive_sense), .pair_dir(pair_dir), .serial_tx_enable(serial_tx_enable),
    .autoneg_enable(autoneg_enable));
  ctl_model u_ctl (.ref_clk(ref_clk), .drive_sense(drive_sense), .ctl_sense(ctl_sense),
    .ctl_reset(ctl_reset), .drive_seen(drive_seen));
  task automatic chk(input string n, input logic [3:0] s, input logic [3:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic set_link(input logic [2:0] v, input logic [1:0] opt, input int n);
    @(posedge ref_clk);
    link_status <= v;
    lamp_option <= opt;
    tick(n);
  endtask
  task automatic flips(input bit act, input logic [3:0] e);
    logic p;
    int f;
    f = 0;
    p = act ? lamps.activity_lamp : lamps.link_presence_lamp;
    repeat (16) begin
      tick(1);
      if ((act ? lamps.activity_lamp : lamps.link_presence_lamp) !== p) f++;
      p = act ? lamps.activity_lamp : lamps.link_presence_lamp;
    end
    chk("lamp_flips", f[3:0], e);
  endtask
  task automatic t_pairs();
    @(posedge ref_clk);
    mdix_mode <= 1'h1;
    tick(2);
    chk("pair_mdix", pair_dir, 4'h1);
    @(posedge ref_clk);
    mdix_mode <= 1'h0;
    tick(2);
    chk("pair_mdi", pair_dir, 4'h2);
    chk("autoneg", autoneg_enable, 4'h1);
    chk("serial_tx", serial_tx_enable, 4'h1);
  endtask
  task automatic t_presence();
    u_ctl.drive(1'h1, 1'h0);
    tick(1);
    chk("present", ctl_present, 4'h1);
    chk("drive_seen", drive_seen, 4'h1);
    u_ctl.drive(1'h0, 1'h0);
    tick(1);
    chk("loss_drop", nexus_loss, 4'h1);
    chk("absent", ctl_present, 4'h0);
    tick(1);
    chk("loss_once", nexus_loss, 4'h0);
  endtask
  task automatic t_reset_ind();
    u_ctl.drive(1'h1, 1'h0);
    u_ctl.drive(1'h1, 1'h1);
    tick(1);
    chk("reset_ind", port_reset_ind, 4'h1);
    chk("loss_reset", nexus_loss, 4'h1);
    tick(1);
    chk("reset_once", {port_reset_ind, nexus_loss}, 4'h0);
    u_ctl.drive(1'h1, 1'h0);
  endtask
  task automatic t_lamps();
    set_link(3'h4, 2'h0, 24);
    chk("both_idle", lamps, 4'h2);
    set_link(3'h6, 2'h0, 2);
    flips(1'b1, 4'(16 / HALF));
    set_link(3'h5, 2'h0, 2);
    flips(1'b1, 4'(16 / HALF));
    set_link(3'h4, 2'h0, 24);
    chk("act_off", lamps.activity_lamp, 4'h0);
    set_link(3'h0, 2'h0, 2);
    chk("no_signal", lamps.link_presence_lamp, 4'h0);
    set_link(3'h4, 2'h1, 24);
    flips(1'b0, 4'h0);
    chk("single_on", lamps.link_presence_lamp, 4'h1);
    set_link(3'h6, 2'h1, 2);
    flips(1'b0, 4'(16 / HALF));
    set_link(3'h0, 2'h1, 2);
    chk("single_off", lamps.link_presence_lamp, 4'h0);
  endtask
  // enable low must hold every lamp where it stands
  task automatic t_freeze();
    set_link(3'h4, 2'h0, 24);
    @(posedge ref_clk);
    clk_en <= 1'h0;
    link_status <= 3'h0;
    tick(3);
    chk("freeze_lamps", lamps, 4'h2);
    @(posedge ref_clk);
    clk_en <= 1'h1;
    tick(1);
    chk("thaw_lamps", lamps, 4'h0);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    tick(3);
    chk("lamps_rst", lamps, 4'h0);
    chk("sense_rst", drive_sense, 4'h0);
    @(posedge ref_clk);
    resetn <= 1'h1;
    tick(2);
    t_pairs();
    t_presence();
    t_reset_ind();
    t_lamps();
    t_freeze();
    report_and_stop();
  end
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
